/* rtl/pioi_pkg.sv */
// constants and types shared by the pio input register block
package pioi_pkg;

  // ---------------------------------------------------------------
  // cell placement
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIOI_EDGE_LEFT,
    PIOI_EDGE_TOP,
    PIOI_EDGE_BOTTOM,
    PIOI_EDGE_RIGHT
  } pioi_edge_t;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_BANK    = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;

  // ctrl fields
  localparam int          CTL_DDR     = 0;
  localparam int          CTL_FIXDLY  = 1;
  localparam int          CTL_DYNDLY  = 2;
  localparam int          CTL_DOFF    = 3;
  localparam int          CTL_COFF    = 4;
  localparam int          CTL_INIT    = 5;
  localparam int          CTL_CFGDONE = 6;
  localparam int          CTL_STREAM  = 7;
  localparam logic [7:0]  CTRL_RST    = 8'h00;

  // status fields
  localparam int          STA_RISE    = 0;
  localparam int          STA_FALL    = 1;
  localparam int          STA_OVR     = 2;
  localparam int          STA_LSR     = 3;
  localparam int          STA_CODE_LO = 4;

  // banks and delay line
  localparam int          NBANK       = 8;
  localparam logic [7:0]  BANK_RST    = 8'h00;
  localparam int          DCODE_W     = 5;
  localparam int          DLY_TAPS    = 32;
  localparam logic [4:0]  FIX_TAP     = 5'h00;

  // sample fifo
  localparam int          FIFO_W      = 2;
  localparam int          FIFO_D      = 4;

endpackage

/* rtl/pioi_top.sv */
// pio input register block with apb control and sample fifo
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps

module pioi_fifo #(
  parameter int W = 2,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // fill side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // drain side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_r != (AW+1)'(D));
  assign o_valid = (cnt_r != '0);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem_r[rp_r];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module pioi_top #(
  parameter pioi_pkg::pioi_edge_t EDGE = pioi_pkg::PIOI_EDGE_BOTTOM
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // pad side
  input  wire logic        i_pad_in,
  input  wire logic        i_pad_clk_in,
  output logic             o_pad_out,
  output logic             o_pad_oe,
  output logic             o_pad_tristate_out,
  // core side
  input  wire logic        i_core_data,
  input  wire logic        i_core_tristate,
  input  wire logic        i_lsr,
  input  wire logic [4:0]  i_dyn_delay_code,
  output logic             o_bypass_comb_in,
  output logic             o_bypass_clock_in,
  output logic             o_rise_sample_out,
  output logic             o_fall_or_sdr_sample_out,
  output logic [7:0]       o_bank_buf_off,
  // right-edge strobe logic
  input  wire logic        i_strobe_read_shifted_clk,
  input  wire logic        i_strobe_write_shifted_clk,
  input  wire logic        i_strobe_capture_polarity,
  output logic             o_strobe_read_clk,
  output logic             o_strobe_write_clk,
  // sample stream
  output logic             o_strm_valid,
  input  wire logic        i_strm_ready,
  output logic [1:0]       o_strm_data
);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == pioi_pkg::OFS_CTRL) || (a == pioi_pkg::OFS_BANK) ||
              (a == pioi_pkg::OFS_STATUS);
  endfunction

  logic [7:0]  ctrl_r;
  logic [7:0]  bank_r;
  logic        ovr_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        wr_go;
  logic        acc;
  logic [31:0] rd_nxt;

  // answer one cycle into the access phase
  assign acc      = i_psel & i_penable;
  assign wr_go    = acc & pready_r & i_pwrite & addr_ok(i_paddr);
  assign o_pready = pready_r;
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (i_paddr)
      pioi_pkg::OFS_CTRL:   rd_nxt[7:0] = ctrl_r;
      pioi_pkg::OFS_BANK:   rd_nxt[7:0] = bank_r;
      pioi_pkg::OFS_STATUS: rd_nxt[8:0] = {i_dyn_delay_code, i_lsr, ovr_r,
                                           o_fall_or_sdr_sample_out,
                                           o_rise_sample_out};
      default:              rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc & ~pready_r;
      prdata_r  <= (acc & ~pready_r & ~i_pwrite) ? rd_nxt : prdata_r;
      pslverr_r <= acc & ~pready_r & ~addr_ok(i_paddr);
    end
  end

  // cfg-done bit is set-only until i_rst: once set, only i_rst, i_core_tristate or i_lsr puts the pad back in tristate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r <= pioi_pkg::CTRL_RST;
    end else if (wr_go && i_paddr == pioi_pkg::OFS_CTRL) begin
      ctrl_r <= i_pwdata[7:0] |
                (ctrl_r & (8'h01 << pioi_pkg::CTL_CFGDONE));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bank_r <= pioi_pkg::BANK_RST;
    end else if (wr_go && i_paddr == pioi_pkg::OFS_BANK) begin
      bank_r <= i_pwdata[7:0];
    end
  end
  assign o_bank_buf_off = bank_r;

  // ---------------------------------------------------------------
  // input buffers, bypass and delay
  // ---------------------------------------------------------------
  logic                pad_buf;
  logic [31:0]         dly_r;
  logic                pad_sel;
  logic                dyn_ok;

  // a switched-off buffer reads as constant low
  assign pad_buf           = i_pad_in & ~ctrl_r[pioi_pkg::CTL_DOFF];
  assign o_bypass_comb_in  = pad_buf;
  assign o_bypass_clock_in = i_pad_clk_in &
                             ~ctrl_r[pioi_pkg::CTL_COFF];
  assign dyn_ok = (EDGE == pioi_pkg::PIOI_EDGE_BOTTOM) &
                  ctrl_r[pioi_pkg::CTL_DYNDLY];

  // delay modelled as a tapped chain of clock stages
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dly_r <= 32'h0000_0000;
    end else begin
      dly_r <= {dly_r[30:0], pad_buf};
    end
  end

  always_comb begin
    if (dyn_ok) begin
      pad_sel = dly_r[i_dyn_delay_code];
    end else if (ctrl_r[pioi_pkg::CTL_FIXDLY]) begin
      pad_sel = dly_r[pioi_pkg::FIX_TAP];
    end else begin
      pad_sel = pad_buf;
    end
  end

  // ---------------------------------------------------------------
  // capture registers
  // ---------------------------------------------------------------
  logic fall_neg_r;
  logic rise_r;
  logic second_r;
  logic init_v;
  logic pol_swap;

  assign init_v   = ctrl_r[pioi_pkg::CTL_INIT];
  // strobe polarity only swaps phases in right-edge cells
  assign pol_swap = (EDGE == pioi_pkg::PIOI_EDGE_RIGHT) &
                    i_strobe_capture_polarity;

  always_ff @(negedge i_clk) begin
    if (i_rst) begin
      fall_neg_r <= 1'b0;
    end else if (i_lsr) begin
      fall_neg_r <= init_v;
    end else begin
      fall_neg_r <= pad_sel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rise_r   <= 1'b0;
      second_r <= 1'b0;
    end else if (i_lsr) begin
      rise_r   <= init_v;
      second_r <= init_v;
    end else if (ctrl_r[pioi_pkg::CTL_DDR]) begin
      rise_r   <= pol_swap ? fall_neg_r : pad_sel;
      second_r <= pol_swap ? pad_sel : fall_neg_r;
    end else begin
      rise_r   <= pad_sel;
      second_r <= pad_sel;
    end
  end
  assign o_rise_sample_out        = rise_r;
  assign o_fall_or_sdr_sample_out = second_r;

  assign o_strobe_read_clk  = (EDGE == pioi_pkg::PIOI_EDGE_RIGHT) &
                              i_strobe_read_shifted_clk;
  assign o_strobe_write_clk = (EDGE == pioi_pkg::PIOI_EDGE_RIGHT) &
                              i_strobe_write_shifted_clk;

  // ---------------------------------------------------------------
  // pad output and tristate
  // ---------------------------------------------------------------
  logic pad_out_r;
  logic tri_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pad_out_r <= 1'b0;
      tri_r     <= 1'b1;
    end else if (i_lsr) begin
      pad_out_r <= init_v;
      tri_r     <= 1'b1;
    end else begin
      pad_out_r <= i_core_data;
      tri_r     <= i_core_tristate | ~ctrl_r[pioi_pkg::CTL_CFGDONE];
    end
  end
  assign o_pad_out          = pad_out_r;
  assign o_pad_tristate_out = tri_r;
  assign o_pad_oe           = ~tri_r;

  // ---------------------------------------------------------------
  // sample stream through fifo
  // ---------------------------------------------------------------
  logic strm_push;
  logic fifo_rdy;
  logic ovr_clr;

  // a full fifo drops the pair and flags an overrun
  assign strm_push = ctrl_r[pioi_pkg::CTL_STREAM] & ~i_lsr;
  assign ovr_clr   = wr_go && i_paddr == pioi_pkg::OFS_STATUS &&
                     i_pwdata[pioi_pkg::STA_OVR];

  pioi_fifo #(
    .W(pioi_pkg::FIFO_W),
    .D(pioi_pkg::FIFO_D)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (strm_push),
    .o_ready (fifo_rdy),
    .i_data  ({second_r, rise_r}),
    .o_valid (o_strm_valid),
    .i_ready (i_strm_ready),
    .o_data  (o_strm_data)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovr_r <= 1'b0;
    end else if (strm_push & ~fifo_rdy) begin
      ovr_r <= 1'b1;
    end else if (ovr_clr) begin
      ovr_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_bypass;
    @(posedge i_clk) disable iff (i_rst)
    o_bypass_comb_in == (i_pad_in & ~ctrl_r[pioi_pkg::CTL_DOFF]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass data mismatch");

  property p_fixdly;
    @(posedge i_clk) disable iff (i_rst)
    (!i_lsr && !dyn_ok && ctrl_r[pioi_pkg::CTL_FIXDLY] &&
     !ctrl_r[pioi_pkg::CTL_DDR]) |=> second_r == $past(pad_buf, 2);
  endproperty
  a_fixdly: assert property (p_fixdly)
    else $error("fixed delay not one stage");

  property p_sdr;
    @(posedge i_clk) disable iff (i_rst)
    (!i_lsr && !ctrl_r[pioi_pkg::CTL_DDR] && !dyn_ok &&
     !ctrl_r[pioi_pkg::CTL_FIXDLY]) |=> second_r == $past(pad_buf)
                                      && rise_r == $past(pad_buf);
  endproperty
  a_sdr: assert property (p_sdr)
    else $error("sdr capture wrong");

  property p_ddr_rise;
    @(posedge i_clk) disable iff (i_rst)
    (!i_lsr && ctrl_r[pioi_pkg::CTL_DDR] && !pol_swap) |=>
      rise_r == $past(pad_sel);
  endproperty
  a_ddr_rise: assert property (p_ddr_rise)
    else $error("rising sample not on first output");

  property p_lsr;
    @(posedge i_clk) disable iff (i_rst)
    i_lsr |=> rise_r == $past(init_v) && second_r == $past(init_v);
  endproperty
  a_lsr: assert property (p_lsr)
    else $error("local reset did not init captures");

  property p_cfg;
    @(posedge i_clk) disable iff (i_rst)
    !ctrl_r[pioi_pkg::CTL_CFGDONE] |=> o_pad_tristate_out && !o_pad_oe;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("pad driven before configuration");

  property p_cfg_sticky;
    @(posedge i_clk) disable iff (i_rst)
    ctrl_r[pioi_pkg::CTL_CFGDONE] |=> ctrl_r[pioi_pkg::CTL_CFGDONE];
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky)
    else $error("configuration done bit fell");

  property p_padout;
    @(posedge i_clk) disable iff (i_rst)
    !i_lsr |=> o_pad_out == $past(i_core_data);
  endproperty
  a_padout: assert property (p_padout)
    else $error("pad data not following core");

  property p_strobe;
    @(posedge i_clk) disable iff (i_rst)
    (EDGE != pioi_pkg::PIOI_EDGE_RIGHT) |->
      !o_strobe_read_clk && !o_strobe_write_clk;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe clock outside right edge");

endmodule

/* dv/pioi_partner.sv */
// pad input buffer and pad clock model facing the pio input block
`timescale 1ns/1ps

module pioi_partner (
  // clock
  input  wire logic i_clk,
  // pattern chosen by the bench
  input  wire logic i_rise_val,
  input  wire logic i_fall_val,
  input  wire logic i_clk_run,
  // pad side
  output logic      o_pad_in,
  output logic      o_pad_clk_in
);
  // ---------------------------------------------------------------
  // pad data changes every half period
  // ---------------------------------------------------------------
  // low phase holds the rising-edge value, high phase the falling one
  always @(i_clk) begin
    o_pad_in <= i_clk ? i_fall_val : i_rise_val;
  end
  // ---------------------------------------------------------------
  // pad clock: stands still low unless running
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    o_pad_clk_in <= i_clk_run & ~o_pad_clk_in;
  end
endmodule

/* dv/tb_top.sv */
// self-checking bench for the pio input register block
`timescale 1ns/1ps

module tb_top;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, err;
  logic [7:0]  paddr, bank_off;
  logic [31:0] pwdata, prdata, rd;
  logic        pad, pclk, rv, fv, crun, cdat, ctri, lsr;
  logic [4:0]  code;
  logic        pout, poe, ptri, bcomb, bclk, rise, sec;
  logic        srd, swr, sval, srdy;
  logic        pol, rise_re, sec_re, srd_re, swr_re;
  logic [1:0]  sdat;
  int          failures, cmp_count, cyc, n;

  pioi_partner i_partner (.i_clk(clk), .i_rise_val(rv), .i_fall_val(fv),
    .i_clk_run(crun), .o_pad_in(pad), .o_pad_clk_in(pclk));

  pioi_top i_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_pad_in(pad), .i_pad_clk_in(pclk), .o_pad_out(pout),
    .o_pad_oe(poe), .o_pad_tristate_out(ptri), .i_core_data(cdat),
    .i_core_tristate(ctri), .i_lsr(lsr), .i_dyn_delay_code(code),
    .o_bypass_comb_in(bcomb), .o_bypass_clock_in(bclk),
    .o_rise_sample_out(rise), .o_fall_or_sdr_sample_out(sec),
    .o_bank_buf_off(bank_off), .i_strobe_read_shifted_clk(clk),
    .i_strobe_write_shifted_clk(clk), .i_strobe_capture_polarity(pol),
    .o_strobe_read_clk(srd), .o_strobe_write_clk(swr),
    .o_strm_valid(sval), .i_strm_ready(srdy), .o_strm_data(sdat));

  // right-edge cell on the same bus and pad, for strobe and polarity
  pioi_top #(.EDGE(pioi_pkg::PIOI_EDGE_RIGHT)) i_dut_re (.i_clk(clk),
    .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(), .o_prdata(),
    .o_pslverr(), .i_pad_in(pad), .i_pad_clk_in(pclk), .o_pad_out(),
    .o_pad_oe(), .o_pad_tristate_out(), .i_core_data(cdat),
    .i_core_tristate(ctri), .i_lsr(lsr), .i_dyn_delay_code(code),
    .o_bypass_comb_in(), .o_bypass_clock_in(),
    .o_rise_sample_out(rise_re), .o_fall_or_sdr_sample_out(sec_re),
    .o_bank_buf_off(), .i_strobe_read_shifted_clk(clk),
    .i_strobe_write_shifted_clk(~clk), .i_strobe_capture_polarity(pol),
    .o_strobe_read_clk(srd_re), .o_strobe_write_clk(swr_re),
    .o_strm_valid(), .i_strm_ready(1'h1), .o_strm_data());

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      $display("[FAIL] %0t run timed out", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // apb transfer; a slow slave is waited on, the timeout cuts a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd   = prdata;
    err  = pslverr;
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask

  // cycles from a pad step to the first registered output
  task automatic lat(input int exp);
    @(posedge clk);
    rv <= 1'h0;
    fv <= 1'h0;
    repeat (40) @(posedge clk);
    rv <= 1'h1;
    fv <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      #1;
    end while (rise !== 1'h1 && n < 60);
    check(n, exp);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {psel, pen, pwr, rv, fv, crun, cdat, lsr, srdy, pol} = '0;
    {paddr, pwdata, code} = '0;
    ctri = 1'h1;
    rst  = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, pioi_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, pioi_pkg::OFS_BANK, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h0c, 32'h0);
    check(err, 1'h1);
    check(rd, 32'h0);
    check({ptri, poe, srd, swr}, 4'h8);
    $display("reset and map test done");
    @(posedge clk);
    cdat <= 1'h1;
    ctri <= 1'h0;
    tick(3);
    check(ptri, 1'h1);
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h40);
    tick(2);
    check({ptri, poe, pout}, 3'h3);
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h0);
    apb(1'h0, pioi_pkg::OFS_CTRL, 32'h0);
    check(rd[6], 1'h1);
    $display("configuration release test done");
    @(posedge clk);
    rv   <= 1'h1;
    fv   <= 1'h1;
    crun <= 1'h1;
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h40);
    tick(2);
    check(bcomb, 1'h1);
    check({srd_re, swr_re}, 2'h2);
    check(bclk, pclk);
    tick(1);
    check(bclk, pclk);
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h58);
    tick(1);
    check({bcomb, bclk}, 2'h0);
    tick(1);
    check({bcomb, bclk}, 2'h0);
    @(posedge clk);
    crun <= 1'h0;
    $display("bypass test done");
    for (int m = 0; m < 3; m++) begin
      for (int v = 0; v < 4; v++) begin
        logic es;
        es = (m != 0) ? v[0] : v[1];
        @(posedge clk);
        rv  <= v[1];
        fv  <= v[0];
        pol <= (m == 1);
        apb(1'h1, pioi_pkg::OFS_CTRL, 32'h40 | 32'(m != 0));
        tick(4);
        check(rise, v[1]);
        check(sec, es);
        check(rise_re, (m == 1) ? v[0] : v[1]);
        check(sec_re, (m == 2) ? v[0] : v[1]);
        apb(1'h0, pioi_pkg::OFS_STATUS, 32'h0);
        check(rd[1:0], {es, v[1]});
      end
    end
    $display("capture mode test done");
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h40);
    lat(1);
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h42);
    lat(2);
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h44);
    lat(2);
    @(posedge clk);
    code <= 5'h1f;
    lat(33);
    apb(1'h0, pioi_pkg::OFS_STATUS, 32'h0);
    check(rd[8:4], 5'h1f);
    code <= 5'h05;
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h46);
    lat(7);
    $display("delay test done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      rv <= 1'h0;
      fv <= 1'h0;
      apb(1'h1, pioi_pkg::OFS_CTRL, 32'h60 | 32'(m));
      tick(4);
      @(posedge clk);
      lsr <= 1'h1;
      tick(2);
      check({rise, sec, ptri}, 3'h7);
      apb(1'h0, pioi_pkg::OFS_STATUS, 32'h0);
      check(rd[3], 1'h1);
      lsr <= 1'h0;
      tick(3);
      check({rise, sec, ptri}, 3'h0);
    end
    $display("local set reset test done");
    apb(1'h1, pioi_pkg::OFS_BANK, 32'ha5);
    tick(0);
    check(bank_off, 8'ha5);
    apb(1'h0, pioi_pkg::OFS_BANK, 32'h0);
    check(rd, 32'ha5);
    $display("bank test done");
    @(posedge clk);
    rv <= 1'h1;
    fv <= 1'h1;
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'hc0);
    tick(8);
    apb(1'h1, pioi_pkg::OFS_CTRL, 32'h40);
    apb(1'h0, pioi_pkg::OFS_STATUS, 32'h0);
    check(rd[2], 1'h1);
    apb(1'h1, pioi_pkg::OFS_STATUS, 32'h4);
    apb(1'h0, pioi_pkg::OFS_STATUS, 32'h0);
    check(rd[2], 1'h0);
    @(posedge clk);
    srdy <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      #1;
      check({sval, sdat}, 3'h7);
      @(posedge clk);
    end
    srdy <= 1'h0;
    #1;
    check(sval, 1'h0);
    $display("stream test done");
    tally_and_finish();
  end
endmodule
